// [verilog/bcp_consts.vh]
// Constants for the line blockage check parameter bank
`ifndef BCP_CONSTS_VH
`define BCP_CONSTS_VH

// Parameter indices
`define BCP_IDX_CHECK_MODE      12'h812
`define BCP_IDX_SAMPLE_PERIOD   12'h813
`define BCP_IDX_ALERT_PRIORITY  12'h814
`define BCP_IDX_RESULT_FLAGS    12'h815
`define BCP_IDX_HIGH_ALERT      12'h816
`define BCP_IDX_LOW_ALERT       12'h817
`define BCP_IDX_ALARM_LINK_MASK 12'h818

// Reset values
`define BCP_RST_CHECK_MODE      8'h00
`define BCP_RST_SAMPLE_PERIOD   16'h00B4
`define BCP_RST_ALERT_PRIORITY  8'h01
`define BCP_RST_RESULT_FLAGS    16'h0000
`define BCP_RST_ALARM_LINK_MASK 16'h08FC

// Check mode codes
`define BCP_MODE_STOP           8'h00
`define BCP_MODE_CALC           8'h01
`define BCP_MODE_REF            8'h02

// Block mode codes and write classes
`define BCP_BLK_OOS             2'h0
`define BCP_BLK_MAN             2'h1
`define BCP_BLK_AUTO            2'h2
`define BCP_WCLASS_OOS          2'h0
`define BCP_WCLASS_MAN          2'h1
`define BCP_WCLASS_AUTO         2'h2

// Sampling period limits in seconds
`define BCP_PERIOD_MIN          16'h0014
`define BCP_PERIOD_MAX          16'hFFFF

// Result flag bit positions
`define BCP_BIT_A_BLOCK         2
`define BCP_BIT_LO_FLUCT        3
`define BCP_BIT_HI_FLUCT        4
`define BCP_BIT_LO_BLOCK        5
`define BCP_BIT_HI_BLOCK        6
`define BCP_BIT_B_BLOCK         7
`define BCP_BIT_INV_BLKF        8
`define BCP_BIT_INV_HI          9
`define BCP_BIT_INV_LO          10
`define BCP_BIT_INV_DIFF        11
`define BCP_BIT_OUT_RANGE       12
`define BCP_BIT_FLG_TEMP_LO     13
`define BCP_BIT_FLG_TEMP_HI     14
`define BCP_BIT_PV_LINK         15

// Timing
`define BCP_TICK_S              1
`define BCP_CLK_MHZ             125
`define BCP_TICK_CYCLES         (`BCP_TICK_S * `BCP_CLK_MHZ * 1000000)
`define BCP_CONSEC_DEFAULT      3

`endif

// [verilog/bcp_consec_filter.v]
// Consecutive-evaluation filter for the blockage conditions
`timescale 1ns/1ps
`include "bcp_consts.vh"

module bcp_consec_filter #(
    parameter N_COND   = 6,
    parameter CNT_W    = 4,
    parameter CONSEC_N = `BCP_CONSEC_DEFAULT
) (
    input  wire              clk,
    input  wire              reset,
    input  wire              eval_stb,
    input  wire              clear,
    input  wire [N_COND-1:0] cross_in,
    output wire [N_COND-1:0] detect
);

    localparam [CNT_W-1:0] LIMIT = CONSEC_N[CNT_W-1:0];

    genvar g;
    generate
        for (g = 0; g < N_COND; g = g + 1) begin : g_cond
            reg [CNT_W-1:0] cnt_q;
            reg             det_q;
            always @(posedge clk) begin
                if (reset || clear) begin
                    cnt_q <= {CNT_W{1'b0}};
                    det_q <= 1'b0;
                end else if (eval_stb) begin
                    // Any miss restarts the run and clears the alarm
                    if (!cross_in[g]) begin
                        cnt_q <= {CNT_W{1'b0}};
                        det_q <= 1'b0;
                    end else begin
                        if (cnt_q < LIMIT)
                            cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
                        det_q <= (cnt_q + {{(CNT_W-1){1'b0}}, 1'b1}) >= LIMIT;
                    end
                end
            end
            assign detect[g] = det_q;
        end
    endgenerate

endmodule // bcp_consec_filter

// [verilog/bcp_param_bank.v]
// Parameter bank and mode control for the line blockage check
//
// Contract
// - Check mode codes: 0 stop, 1 calculate, 2 reference; stopped after reset.
// - In stop mode no evaluation runs and result flags other than bit 15 keep their values.
// - In calculate mode evaluate every period; alarms follow each outcome.
// - Writing reference mode captures new references, then mode becomes calculate.
// - Sampling period is 20 to 65535 seconds, 180 after reset.
// - Period, priority and link mask writes are accepted only while stopped.
// - Write class gates writes by block mode: O/S, manual, automatic.
// - One priority value serves both alerts, default 1.
// - Bits 8-11 invalid references, 12 out of range, 13-14 flange temperature.
// - Bit 15 shows an abnormality linked to the three process value statuses.
// - High-side alert from A, B, high fluctuation/blockage, invalid refs, range.
// - Low-side alert from A, B, low fluctuation/blockage, invalid refs, range.
// - Link mask selects flags for analog alert and display; resets to 0x08FC.
// - Mask bit 15 set and abnormality marks process values uncertain.
// - Blockage declared after a set number of consecutive crossings, default 3.
`timescale 1ns/1ps
`include "bcp_consts.vh"

module bcp_param_bank #(
    parameter TICK_CYCLES = `BCP_TICK_CYCLES,
    parameter CONSEC_N    = `BCP_CONSEC_DEFAULT
) (
    input  wire        clk,
    input  wire        reset,
    input  wire [1:0]  block_mode,
    input  wire        param_wr,
    input  wire        param_rd,
    input  wire [11:0] param_index,
    input  wire [15:0] param_wdata,
    output reg  [15:0] param_rdata,
    output reg         param_rd_valid,
    output reg         param_wr_ack,
    output reg         param_wr_reject,
    input  wire [5:0]  cond_cross,
    input  wire        out_of_range_in,
    input  wire        flange_temp_low_in,
    input  wire        flange_temp_high_in,
    output reg         ref_capture_req,
    input  wire        ref_capture_done,
    input  wire [3:0]  ref_invalid_in,
    output reg         eval_pulse,
    output reg  [7:0]  check_mode_out,
    output reg  [7:0]  alert_priority_out,
    output reg         high_side_alert_out,
    output reg         low_side_alert_out,
    output reg  [15:0] alert_forward,
    output reg         pv_status_uncertain
);

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RUN  = 2'h1;
    localparam [1:0] ST_REF  = 2'h2;

    localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

    // Every parameter in this bank belongs to the automatic write class
    localparam [1:0] WCLASS = `BCP_WCLASS_AUTO;

    reg  [7:0]  check_mode_q;
    reg  [7:0]  check_mode_d;
    reg  [15:0] sample_period_q;
    reg  [7:0]  alert_priority_q;
    reg  [15:0] alarm_link_mask_q;
    reg  [15:0] result_flags_q;
    reg  [3:0]  ref_invalid_q;
    reg  [1:0]  state_q;
    reg  [1:0]  state_d;
    reg  [31:0] tick_cnt_q;
    reg  [15:0] sec_cnt_q;
    reg         eval_stb_q;
    reg         filt_clear;

    wire [5:0]  detect;
    wire [15:0] flags_view;
    wire        high_alert;
    wire        low_alert;
    wire        abnormal;
    wire        eval_now;   // One cycle ahead of eval_stb_q so flags take this outcome

    reg         class_ok;
    reg         stopped;
    reg         wr_ok;
    reg         wr_bad;
    reg  [15:0] rd_mux;

    bcp_consec_filter #(
        .N_COND   (6),
        .CNT_W    (4),
        .CONSEC_N (CONSEC_N)
    ) u_filter (
        .clk      (clk),
        .reset    (reset),
        .eval_stb (eval_now),
        .clear    (filt_clear),
        .cross_in (cond_cross),
        .detect   (detect)
    );

    // Block mode against write class
    always @* begin
        case (WCLASS)
            `BCP_WCLASS_OOS:  class_ok = (block_mode == `BCP_BLK_OOS);
            `BCP_WCLASS_MAN:  class_ok = (block_mode == `BCP_BLK_OOS) ||
                                         (block_mode == `BCP_BLK_MAN);
            `BCP_WCLASS_AUTO: class_ok = (block_mode == `BCP_BLK_OOS) ||
                                         (block_mode == `BCP_BLK_MAN) ||
                                         (block_mode == `BCP_BLK_AUTO);
            default:          class_ok = 1'b0;
        endcase
    end

    // Write acceptance decode
    always @* begin
        stopped = (check_mode_q == `BCP_MODE_STOP);
        wr_ok   = 1'b0;
        wr_bad  = 1'b0;
        if (param_wr) begin
            if (!class_ok) begin
                wr_bad = 1'b1;
            end else if (param_index == `BCP_IDX_CHECK_MODE) begin
                // Codes above reference are undefined
                if (param_wdata[15:8] == 8'h00 && param_wdata[7:0] <= `BCP_MODE_REF)
                    wr_ok = 1'b1;
                else
                    wr_bad = 1'b1;
            end else if (param_index == `BCP_IDX_SAMPLE_PERIOD) begin
                if (stopped && param_wdata >= `BCP_PERIOD_MIN && param_wdata <= `BCP_PERIOD_MAX)
                    wr_ok = 1'b1;
                else
                    wr_bad = 1'b1;
            end else if (param_index == `BCP_IDX_ALERT_PRIORITY) begin
                if (stopped && param_wdata[15:8] == 8'h00)
                    wr_ok = 1'b1;
                else
                    wr_bad = 1'b1;
            end else if (param_index == `BCP_IDX_ALARM_LINK_MASK) begin
                if (stopped)
                    wr_ok = 1'b1;
                else
                    wr_bad = 1'b1;
            end else begin
                // Read-only and unknown indices refuse writes
                wr_bad = 1'b1;
            end
        end
    end

    // Mode sequencer
    always @* begin
        state_d      = state_q;
        check_mode_d = check_mode_q;
        filt_clear   = 1'b0;
        if (wr_ok && param_index == `BCP_IDX_CHECK_MODE)
            check_mode_d = param_wdata[7:0];
        case (state_q)
            ST_IDLE: begin
                if (check_mode_d == `BCP_MODE_CALC) begin
                    state_d    = ST_RUN;
                    filt_clear = 1'b1;
                end else if (check_mode_d == `BCP_MODE_REF) begin
                    state_d    = ST_REF;
                end
            end
            ST_RUN: begin
                if (check_mode_d == `BCP_MODE_STOP) begin
                    state_d = ST_IDLE;
                end else if (check_mode_d == `BCP_MODE_REF) begin
                    state_d = ST_REF;
                end
            end
            ST_REF: begin
                if (check_mode_d == `BCP_MODE_STOP) begin
                    state_d = ST_IDLE;
                end else if (check_mode_d == `BCP_MODE_CALC) begin
                    state_d    = ST_RUN;
                    filt_clear = 1'b1;
                end else if (ref_capture_done) begin
                    // Capture finished: fall into calculation unaided
                    check_mode_d = `BCP_MODE_CALC;
                    state_d      = ST_RUN;
                    filt_clear   = 1'b1;
                end
            end
            default: begin
                state_d      = ST_IDLE;
                check_mode_d = `BCP_MODE_STOP;
            end
        endcase
    end

    always @(posedge clk) begin
        if (reset) begin
            state_q      <= ST_IDLE;
            check_mode_q <= `BCP_RST_CHECK_MODE;
        end else begin
            state_q      <= state_d;
            check_mode_q <= check_mode_d;
        end
    end

    // Stored parameters
    always @(posedge clk) begin
        if (reset) begin
            sample_period_q   <= `BCP_RST_SAMPLE_PERIOD;
            alert_priority_q  <= `BCP_RST_ALERT_PRIORITY;
            alarm_link_mask_q <= `BCP_RST_ALARM_LINK_MASK;
        end else if (wr_ok) begin
            if (param_index == `BCP_IDX_SAMPLE_PERIOD)
                sample_period_q <= param_wdata;
            if (param_index == `BCP_IDX_ALERT_PRIORITY)
                alert_priority_q <= param_wdata[7:0];
            if (param_index == `BCP_IDX_ALARM_LINK_MASK)
                alarm_link_mask_q <= param_wdata;
        end
    end

    // Reference capture handshake; invalid flags replace the old set
    always @(posedge clk) begin
        if (reset) begin
            ref_capture_req <= 1'b0;
            ref_invalid_q   <= 4'h0;
        end else begin
            ref_capture_req <= (state_d == ST_REF) && !(state_q == ST_REF && ref_capture_done);
            if (state_q == ST_REF && ref_capture_done && check_mode_d == `BCP_MODE_CALC)
                ref_invalid_q <= ref_invalid_in;
        end
    end

    assign eval_now = (state_q == ST_RUN) && !filt_clear && (tick_cnt_q >= TICK_LAST) &&
                      (sec_cnt_q + 16'h0001 >= sample_period_q);

    // Period timer: one second ticks, evaluation when the period is used up
    always @(posedge clk) begin
        if (reset) begin
            tick_cnt_q <= 32'h0000_0000;
            sec_cnt_q  <= 16'h0000;
            eval_stb_q <= 1'b0;
        end else if (state_q != ST_RUN || filt_clear) begin
            // Timer restarts so each run gets a full first period
            tick_cnt_q <= 32'h0000_0000;
            sec_cnt_q  <= 16'h0000;
            eval_stb_q <= 1'b0;
        end else begin
            eval_stb_q <= 1'b0;
            if (tick_cnt_q >= TICK_LAST) begin
                tick_cnt_q <= 32'h0000_0000;
                if (sec_cnt_q + 16'h0001 >= sample_period_q) begin
                    sec_cnt_q  <= 16'h0000;
                    eval_stb_q <= 1'b1;
                end else begin
                    sec_cnt_q <= sec_cnt_q + 16'h0001;
                end
            end else begin
                tick_cnt_q <= tick_cnt_q + 32'h0000_0001;
            end
        end
    end

    // Result flags 2-7 and 12-14 taken only on an evaluation in calculate mode; bits 8-11 and 15 every cycle
    always @(posedge clk) begin
        if (reset) begin
            result_flags_q <= `BCP_RST_RESULT_FLAGS;
        end else begin
            result_flags_q[1:0] <= 2'b00;
            result_flags_q[`BCP_BIT_INV_DIFF:`BCP_BIT_INV_BLKF] <= ref_invalid_q;
            if (eval_stb_q && state_q == ST_RUN) begin
                result_flags_q[`BCP_BIT_B_BLOCK:`BCP_BIT_A_BLOCK] <= detect;
                result_flags_q[`BCP_BIT_OUT_RANGE]   <= out_of_range_in;
                result_flags_q[`BCP_BIT_FLG_TEMP_LO] <= flange_temp_low_in;
                result_flags_q[`BCP_BIT_FLG_TEMP_HI] <= flange_temp_high_in;
            end
            result_flags_q[`BCP_BIT_PV_LINK] <= abnormal && alarm_link_mask_q[`BCP_BIT_PV_LINK];
        end
    end

    assign flags_view = {1'b0, result_flags_q[14:2], 2'b00};

    // Any selected condition counts as an abnormality
    assign abnormal = |(flags_view[14:2] & alarm_link_mask_q[14:2]);

    assign high_alert = flags_view[`BCP_BIT_A_BLOCK]  | flags_view[`BCP_BIT_B_BLOCK] |
                        flags_view[`BCP_BIT_HI_FLUCT] | flags_view[`BCP_BIT_HI_BLOCK] |
                        flags_view[`BCP_BIT_INV_BLKF] | flags_view[`BCP_BIT_INV_HI] |
                        flags_view[`BCP_BIT_INV_DIFF] | flags_view[`BCP_BIT_OUT_RANGE];

    assign low_alert  = flags_view[`BCP_BIT_A_BLOCK]  | flags_view[`BCP_BIT_B_BLOCK] |
                        flags_view[`BCP_BIT_LO_FLUCT] | flags_view[`BCP_BIT_LO_BLOCK] |
                        flags_view[`BCP_BIT_INV_BLKF] | flags_view[`BCP_BIT_INV_LO] |
                        flags_view[`BCP_BIT_INV_DIFF] | flags_view[`BCP_BIT_OUT_RANGE];

    // Read mux
    always @* begin
        if (param_index == `BCP_IDX_CHECK_MODE)
            rd_mux = {8'h00, check_mode_q};
        else if (param_index == `BCP_IDX_SAMPLE_PERIOD)
            rd_mux = sample_period_q;
        else if (param_index == `BCP_IDX_ALERT_PRIORITY)
            rd_mux = {8'h00, alert_priority_q};
        else if (param_index == `BCP_IDX_RESULT_FLAGS)
            rd_mux = result_flags_q;
        else if (param_index == `BCP_IDX_HIGH_ALERT)
            rd_mux = {15'h0000, high_side_alert_out};
        else if (param_index == `BCP_IDX_LOW_ALERT)
            rd_mux = {15'h0000, low_side_alert_out};
        else if (param_index == `BCP_IDX_ALARM_LINK_MASK)
            rd_mux = alarm_link_mask_q;
        else
            rd_mux = 16'h0000;
    end

    // Registered outputs
    always @(posedge clk) begin
        if (reset) begin
            param_rdata         <= 16'h0000;
            param_rd_valid      <= 1'b0;
            param_wr_ack        <= 1'b0;
            param_wr_reject     <= 1'b0;
            eval_pulse          <= 1'b0;
            check_mode_out      <= `BCP_RST_CHECK_MODE;
            alert_priority_out  <= `BCP_RST_ALERT_PRIORITY;
            high_side_alert_out <= 1'b0;
            low_side_alert_out  <= 1'b0;
            alert_forward       <= 16'h0000;
            pv_status_uncertain <= 1'b0;
        end else begin
            param_rdata         <= param_rd ? rd_mux : param_rdata;
            param_rd_valid      <= param_rd;
            param_wr_ack        <= wr_ok;
            param_wr_reject     <= wr_bad;
            eval_pulse          <= eval_stb_q;
            check_mode_out      <= check_mode_q;
            alert_priority_out  <= alert_priority_q;
            high_side_alert_out <= high_alert;
            low_side_alert_out  <= low_alert;
            alert_forward       <= flags_view & alarm_link_mask_q;
            pv_status_uncertain <= abnormal && alarm_link_mask_q[`BCP_BIT_PV_LINK];
        end
    end

endmodule // bcp_param_bank

// [tb/bcp_param_bank_chk.sv]
// Port-level concurrent checks for the parameter bank
`timescale 1ns/1ps
`include "bcp_consts.vh"

module bcp_param_bank_chk #(
    parameter TICK_CYCLES = `BCP_TICK_CYCLES,
    parameter CONSEC_N    = `BCP_CONSEC_DEFAULT
) (
    input wire        clk,
    input wire        reset,
    input wire [1:0]  block_mode,
    input wire        param_wr,
    input wire [11:0] param_index,
    input wire [15:0] param_wdata,
    input wire        param_wr_reject,
    input wire        ref_capture_req,
    input wire        ref_capture_done,
    input wire        eval_pulse,
    input wire [7:0]  check_mode_out,
    input wire [7:0]  alert_priority_out,
    input wire [15:0] alert_forward
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    // Writes that only the stopped mode may take
    wire wr_gated = param_wr && (param_index == `BCP_IDX_SAMPLE_PERIOD ||
                    param_index == `BCP_IDX_ALERT_PRIORITY || param_index == `BCP_IDX_ALARM_LINK_MASK);
    wire wr_ro    = param_wr && param_index >= `BCP_IDX_RESULT_FLAGS && param_index <= `BCP_IDX_LOW_ALERT;

    AST_RST_DEFAULTS: assert property (disable iff (1'b0) reset |=> check_mode_out == `BCP_MODE_STOP &&
        alert_priority_out == `BCP_RST_ALERT_PRIORITY && alert_forward == 16'h0000)
        else $error("defaults not restored by reset");
    AST_MODE_CODE: assert property (check_mode_out <= `BCP_MODE_REF)
        else $error("check mode outside its codes");
    AST_STOP_NO_EVAL: assert property (check_mode_out == `BCP_MODE_STOP &&
        $past(check_mode_out) == `BCP_MODE_STOP && $past(check_mode_out, 2) == `BCP_MODE_STOP |-> !eval_pulse)
        else $error("evaluation while stopped");
    AST_REF_REQ: assert property (param_wr && param_index == `BCP_IDX_CHECK_MODE &&
        param_wdata == 16'h0002 && block_mode != 2'h3 |=> ref_capture_req)
        else $error("reference write without capture request");
    AST_REF_DONE: assert property (ref_capture_req && ref_capture_done && !param_wr |=>
        !ref_capture_req ##1 check_mode_out == `BCP_MODE_CALC)
        else $error("capture end did not switch to calculation");
    AST_PERIOD_MIN: assert property (param_wr && param_index == `BCP_IDX_SAMPLE_PERIOD &&
        param_wdata < `BCP_PERIOD_MIN |=> param_wr_reject)
        else $error("short period accepted");
    AST_GATED_REJ: assert property (wr_gated && check_mode_out != `BCP_MODE_STOP |=> param_wr_reject)
        else $error("gated write accepted while running");
    AST_PRI_FROZEN: assert property (check_mode_out != `BCP_MODE_STOP &&
        $past(check_mode_out) != `BCP_MODE_STOP |-> $stable(alert_priority_out))
        else $error("priority changed while running");
    AST_BLK3_REJ: assert property (param_wr && block_mode == 2'h3 |=> param_wr_reject)
        else $error("write accepted in unknown block mode");
    AST_FWD_B15: assert property (alert_forward[15] == 1'b0)
        else $error("forward bit 15 set");
    AST_RO_REJ: assert property (wr_ro |=> param_wr_reject)
        else $error("read-only word accepted a write");
endmodule // bcp_param_bank_chk

bind bcp_param_bank bcp_param_bank_chk #(.TICK_CYCLES(TICK_CYCLES), .CONSEC_N(CONSEC_N)) u_chk (
    .clk(clk), .reset(reset), .block_mode(block_mode), .param_wr(param_wr), .param_index(param_index),
    .param_wdata(param_wdata), .param_wr_reject(param_wr_reject), .ref_capture_req(ref_capture_req),
    .ref_capture_done(ref_capture_done), .eval_pulse(eval_pulse), .check_mode_out(check_mode_out),
    .alert_priority_out(alert_priority_out), .alert_forward(alert_forward));

// [tb/bcp_capture_model.sv]
// Reference capture engine model answering capture requests
`timescale 1ns/1ps

module bcp_capture_model (
    input  wire       clk,
    input  wire       ref_capture_req,
    input  wire [7:0] delay,
    input  wire [3:0] inv,
    output reg        ref_capture_done,
    output reg  [3:0] ref_invalid_in
);
    reg [7:0] cnt_q = 8'h00;

    initial ref_capture_done = 1'b0;
    initial ref_invalid_in = 4'h0;

    // Done pulse after a delay; flags only meaningful with done, inverted otherwise
    always @(negedge clk) begin
        ref_capture_done <= 1'b0;
        ref_invalid_in <= ~inv;
        cnt_q <= 8'h00;
        if (ref_capture_req && !ref_capture_done) begin
            cnt_q <= cnt_q + 8'h01;
            if (cnt_q == delay) begin
                ref_capture_done <= 1'b1;
                ref_invalid_in <= inv;
            end
        end
    end
endmodule // bcp_capture_model

// [tb/bcp_param_bank_bench.sv]
// Self-checking bench for the parameter bank
`timescale 1ns/1ps
`include "bcp_consts.vh"

module bcp_param_bank_bench;
    localparam TICK = 4;
    localparam PER_CYC = 20 * TICK;
    localparam [11:0] I_MODE = `BCP_IDX_CHECK_MODE;
    localparam [11:0] I_PER = `BCP_IDX_SAMPLE_PERIOD;
    localparam [11:0] I_PRI = `BCP_IDX_ALERT_PRIORITY;
    localparam [11:0] I_FLG = `BCP_IDX_RESULT_FLAGS;
    localparam [11:0] I_MSK = `BCP_IDX_ALARM_LINK_MASK;
    reg         clk = 1'b0;
    reg         reset = 1'b1;
    reg  [1:0]  block_mode = `BCP_BLK_AUTO;
    reg         param_wr = 1'b0;
    reg         param_rd = 1'b0;
    reg  [11:0] param_index = 12'h000;
    reg  [15:0] param_wdata = 16'h0000;
    reg  [5:0]  cond_cross = 6'h00;
    reg         oor = 1'b0;
    reg         t_lo = 1'b0;
    reg  [3:0]  ref_inv = 4'h0;
    wire [15:0] param_rdata, alert_forward;
    wire        param_rd_valid, param_wr_ack, param_wr_reject, eval_pulse, pv_status_uncertain;
    wire        ref_capture_req, ref_capture_done, high_side_alert_out, low_side_alert_out;
    wire [3:0]  ref_invalid_in;
    wire [7:0]  check_mode_out, alert_priority_out;
    integer     err_count = 0;
    integer     compares = 0;
    integer     n;

    always #4 clk = ~clk;

    bcp_param_bank #(.TICK_CYCLES(TICK), .CONSEC_N(3)) u_dut (
        .clk(clk), .reset(reset), .block_mode(block_mode), .param_wr(param_wr), .param_rd(param_rd),
        .param_index(param_index), .param_wdata(param_wdata), .param_rdata(param_rdata),
        .param_rd_valid(param_rd_valid), .param_wr_ack(param_wr_ack), .param_wr_reject(param_wr_reject),
        .cond_cross(cond_cross), .out_of_range_in(oor), .flange_temp_low_in(t_lo),
        .flange_temp_high_in(t_lo), .ref_capture_req(ref_capture_req), .ref_capture_done(ref_capture_done),
        .ref_invalid_in(ref_invalid_in), .eval_pulse(eval_pulse), .check_mode_out(check_mode_out),
        .alert_priority_out(alert_priority_out), .high_side_alert_out(high_side_alert_out),
        .low_side_alert_out(low_side_alert_out), .alert_forward(alert_forward),
        .pv_status_uncertain(pv_status_uncertain));

    bcp_capture_model u_cap (.clk(clk), .ref_capture_req(ref_capture_req), .delay(8'h05), .inv(ref_inv),
        .ref_capture_done(ref_capture_done), .ref_invalid_in(ref_invalid_in));

    task end_sim;
        begin
            if (err_count == 0 && compares > 0)
                $display("DONE - PASS");
            else
                $display("DONE - FAIL");
            $finish;
        end
    endtask

    task chk(input [15:0] seen, input [15:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                err_count = err_count + 1;
                $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask

    task wr(input [11:0] idx, input [15:0] d, input ok);
        begin
            @(negedge clk);
            param_wr = 1'b1;
            param_index = idx;
            param_wdata = d;
            @(negedge clk);
            param_wr = 1'b0;
            chk({param_wr_ack, param_wr_reject}, {ok, ~ok});
        end
    endtask

    task rd(input [11:0] idx, input [15:0] exp);
        begin
            @(negedge clk);
            param_rd = 1'b1;
            param_index = idx;
            @(negedge clk);
            param_rd = 1'b0;
            chk(param_rd_valid, 1'b1);
            chk(param_rdata, exp);
        end
    endtask

    // Gap is checked only when nonzero; give it only when called right after a previous evaluation
    task wait_eval(input integer gap);
        integer c;
        begin
            c = 0;
            @(negedge clk);
            while (eval_pulse !== 1'b1 && c < 300) begin
                @(negedge clk);
                c = c + 1;
            end
            chk(c < 300, 1'b1);
            if (gap > 0)
                chk(c + 1, gap);
        end
    endtask

    task t_reset;
        begin
            rd(I_MODE, 16'h0000);
            rd(I_PER, 16'h00B4);
            rd(I_PRI, 16'h0001);
            rd(I_FLG, 16'h0000);
            rd(`BCP_IDX_HIGH_ALERT, 16'h0000);
            rd(`BCP_IDX_LOW_ALERT, 16'h0000);
            rd(I_MSK, 16'h08FC);
            rd(12'h819, 16'h0000);
        end
    endtask

    task t_access;
        begin
            for (n = 0; n < 4; n = n + 1) begin
                block_mode = n;
                wr(I_PRI, 16'h0003, n != 3);
            end
            block_mode = `BCP_BLK_AUTO;
            chk(alert_priority_out, 16'h0003);
            wr(I_PRI, 16'h0105, 1'b0);
            wr(I_PER, 16'h0013, 1'b0);
            wr(I_PER, 16'hFFFF, 1'b1);
            rd(I_PER, 16'hFFFF);
            wr(I_PER, 16'h0014, 1'b1);
            wr(I_MODE, 16'h0003, 1'b0);
            wr(I_FLG, 16'hFFFF, 1'b0);
            wr(`BCP_IDX_HIGH_ALERT, 16'h0001, 1'b0);
            wr(I_MSK, 16'hF8FC, 1'b1);
        end
    endtask

    task t_eval;
        begin
            cond_cross = 6'h3F;
            oor = 1'b1;
            t_lo = 1'b1;
            wr(I_MODE, 16'h0001, 1'b1);
            wr(I_PER, 16'h0020, 1'b0);
            wr(I_PRI, 16'h0001, 1'b0);
            wr(I_MSK, 16'h0000, 1'b0);
            wait_eval(0);
            wait_eval(PER_CYC);
            rd(I_FLG, 16'hF000);
            wait_eval(0);
            repeat (3) @(negedge clk);
            rd(I_FLG, 16'hF0FC);
            chk(alert_forward, 16'h70FC);
            chk({high_side_alert_out, low_side_alert_out, pv_status_uncertain}, 3'b111);
            cond_cross = 6'h14;
            oor = 1'b0;
            t_lo = 1'b0;
            wait_eval(0);
            repeat (3) @(negedge clk);
            rd(I_FLG, 16'h8050);
            rd(`BCP_IDX_HIGH_ALERT, 16'h0001);
            rd(`BCP_IDX_LOW_ALERT, 16'h0000);
            cond_cross = 6'h0A;
            wait_eval(0);
            repeat (3) @(negedge clk);
            rd(I_FLG, 16'h0000);
            chk(pv_status_uncertain, 1'b0);
            wait_eval(0);
            wait_eval(0);
            repeat (3) @(negedge clk);
            rd(I_FLG, 16'h8028);
            chk({high_side_alert_out, low_side_alert_out}, 2'b01);
        end
    endtask

    task t_stop;
        begin
            wr(I_MODE, 16'h0000, 1'b1);
            cond_cross = 6'h3F;
            oor = 1'b1;
            n = 0;
            repeat (200) begin
                @(negedge clk);
                if (eval_pulse === 1'b1)
                    n = n + 1;
            end
            chk(n, 16'h0000);
            rd(I_FLG, 16'h8028);
        end
    endtask

    task t_ref;
        begin
            cond_cross = 6'h00;
            oor = 1'b0;
            ref_inv = 4'h4;
            wr(I_MODE, 16'h0002, 1'b1);
            chk(ref_capture_req, 1'b1);
            n = 0;
            while (ref_capture_req === 1'b1 && n < 50) begin
                @(negedge clk);
                n = n + 1;
            end
            chk(n < 50, 1'b1);
            repeat (2) @(negedge clk);
            rd(I_MODE, 16'h0001);
            rd(I_FLG, 16'h8428);
            chk({high_side_alert_out, low_side_alert_out}, 2'b01);
        end
    endtask

    initial begin
        repeat (20) @(negedge clk);
        reset = 1'b0;
        t_reset;
        t_access;
        t_eval;
        t_stop;
        t_ref;
        end_sim;
    end

    // Whole run needs about 850 cycles
    initial begin
        repeat (20000) @(posedge clk);
        err_count = err_count + 1;
        end_sim;
    end
endmodule // bcp_param_bank_bench
